// File: timer_pulse_unit_flags_contention_bench.sv
`timescale 1ns/1ns
module timer_pulse_unit_flags_contention_bench;
    logic clk = 1'b0, nrst = 1'b0, wr_s = 1'b0, rd_s = 1'b0, stop = 1'b1, cap = 1'b0, mo;
    logic [2:0] a = 3'h0;
    logic [15:0] d = 16'h0000, rdata, v;
    int error_cnt = 0, n_tests = 0, cyc = 0, t;
    // Rows: register, written value, expected read value
    logic [34:0] rows [6] = '{{3'h0, 16'h0100, 16'h0100}, {3'h1, 16'h1234, 16'h1234},
        {3'h2, 16'h00a5, 16'h00a5}, {3'h4, 16'h0005, 16'h0005},
        {3'h5, 16'h0010, 16'h0010}, {3'h7, 16'h5555, 16'h0000}};
    tpf_if lnk ();
    tpf_host tpf_host_i (.REF_CLK(clk), .NRST(nrst), .ADDR(a), .WDATA(d), .WR(wr_s),
        .RD(rd_s), .RDATA(rdata), .LINK(lnk));
    // External clocks idle low; capture driven by the bench
    tpf_device tpf_device_i (.REF_CLK(clk), .NRST(nrst), .LINK(lnk),
        .EXT_CLK_A(1'b0), .EXT_CLK_B(1'b0),
        .CAPTURE_IN(cap), .MODULE_STOP(stop), .MATCH_OUT(mo));
    tpf_sva tpf_sva_i (.REF_CLK(clk), .NRST(nrst), .t1(lnk.t1), .t2(lnk.t2), .wr(lnk.wr),
        .addr(lnk.addr), .rdata(lnk.rdata), .xfer_ack(lnk.xfer_ack),
        .match_capture_irq(lnk.match_capture_irq), .overflow_irq(lnk.overflow_irq),
        .underflow_irq(lnk.underflow_irq));
    always #4 clk = ~clk;
    // ----------
    // Tasks
    // ----------
    task automatic tally_and_finish();
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", n, e, g);
            error_cnt++;
        end
    endtask
    task automatic hw(input logic [2:0] ad, input logic [15:0] wd);
        @(posedge clk);
        a <= ad;
        d <= wd;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    // Device write; waits out busy so the next command is not dropped
    task automatic dw(input logic [2:0] r, input logic [15:0] wd);
        hw(tpf_pkg::HREG_ADDR, {13'h0000, r});
        hw(tpf_pkg::HREG_DATA, wd);
        hw(tpf_pkg::HREG_CMD, 16'h0001);
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic dr(input logic [2:0] r, input logic c = 1'b0);
        hw(tpf_pkg::HREG_ADDR, {13'h0000, r});
        hw(tpf_pkg::HREG_CMD, 16'h0000);
        if (c) cap <= 1'b1;
        repeat (2) @(posedge clk);
        a <= tpf_pkg::HREG_RESULT;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic tog();
        logic p;
        p = mo;
        t = 0;
        while (mo === p && t < 200) begin
            @(posedge clk);
            #1 t++;
        end
    endtask
    // Hang guard, well above the expected run length
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        foreach (rows[i]) begin
            dw(rows[i][34:32], rows[i][31:16]);
            dr(rows[i][34:32]);
            chk("readback", rows[i][15:0], v);
        end
        // Mid-run reset, then reset values
        @(posedge clk) nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        dr(tpf_pkg::REG_MATCH);
        chk("match_rst", tpf_pkg::MAX16, v);
        dr(tpf_pkg::REG_STATUS);
        chk("status_rst", 16'h0000, v);
        // Period of N+1 ticks of four cycles with clear on match
        dw(tpf_pkg::REG_MATCH, 16'h0003);
        dw(tpf_pkg::REG_IRQ_ENABLE, 16'h0007);
        dw(tpf_pkg::REG_MODE, 16'h0044);
        @(posedge clk) stop <= 1'b0;
        tog();
        tog();
        chk("period", 16'h0010, t[15:0]);
        chk("match_irq", 16'h0001, 16'(lnk.match_capture_irq));
        dw(tpf_pkg::REG_MATCH, 16'h8000);
        dw(tpf_pkg::REG_MODE, 16'h0000);
        dw(tpf_pkg::REG_STATUS, 16'h0000);
        chk("clr_unread", 16'h0001, 16'(lnk.match_capture_irq));
        @(posedge clk) stop <= 1'b1;
        dr(tpf_pkg::REG_STATUS);
        dw(tpf_pkg::REG_STATUS, 16'h0000);
        chk("clr_stopped", 16'h0001, 16'(lnk.match_capture_irq));
        @(posedge clk) stop <= 1'b0;
        dr(tpf_pkg::REG_STATUS);
        chk("status_set", 16'h0001, v & 16'h0001);
        dw(tpf_pkg::REG_STATUS, 16'h0000);
        chk("clr_read", 16'h0000, 16'(lnk.match_capture_irq));
        // Transfer controller takes the next match request
        dw(tpf_pkg::REG_MATCH, 16'h0002);
        dw(tpf_pkg::REG_COUNTER, 16'h0000);
        repeat (20) @(posedge clk);
        hw(tpf_pkg::HREG_DTC_EN, 16'h0001);
        repeat (4) @(posedge clk);
        #1 chk("xfer_clr", 16'h0000, 16'(lnk.match_capture_irq));
        hw(tpf_pkg::HREG_DTC_EN, 16'h0000);
        // Wrap at the match value clears instead of flagging
        dw(tpf_pkg::REG_MATCH, tpf_pkg::MAX16);
        dw(tpf_pkg::REG_MODE, 16'h0004);
        dw(tpf_pkg::REG_COUNTER, 16'hfff8);
        repeat (40) @(posedge clk);
        #1 chk("ovf_clear", 16'h0000, 16'(lnk.overflow_irq));
        chk("ovf_match", 16'h0001, 16'(lnk.match_capture_irq));
        dw(tpf_pkg::REG_MODE, 16'h0000);
        dw(tpf_pkg::REG_COUNTER, 16'hfffc);
        repeat (24) @(posedge clk);
        #1 chk("ovf_irq", 16'h0001, 16'(lnk.overflow_irq));
        dw(tpf_pkg::REG_MODE, 16'h0020);
        dw(tpf_pkg::REG_COUNTER, 16'h0003);
        repeat (24) @(posedge clk);
        #1 chk("udf_irq", 16'h0001, 16'(lnk.underflow_irq));
        // Capture beats a T2 write, then shows in a T1 read
        dw(tpf_pkg::REG_MODE, 16'h0011);
        dw(tpf_pkg::REG_COUNTER, 16'h0123);
        hw(tpf_pkg::HREG_ADDR, {13'h0000, tpf_pkg::REG_MATCH});
        hw(tpf_pkg::HREG_DATA, 16'h5555);
        hw(tpf_pkg::HREG_CMD, 16'h0001);
        @(posedge clk) cap <= 1'b1;
        dr(tpf_pkg::REG_MATCH);
        chk("cap_wins", 16'h0123, v);
        @(posedge clk) cap <= 1'b0;
        dw(tpf_pkg::REG_COUNTER, 16'h0456);
        dr(tpf_pkg::REG_MATCH, 1'b1);
        chk("cap_read", 16'h0456, v);
        tally_and_finish();
    end
endmodule

// File: tpf_count_source.sv
`timescale 1ns/1ns
module tpf_count_source (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Selection
    input wire logic [1:0] src,
    input wire logic down_sel,
    input wire logic halt,
    // External clock inputs
    input wire logic ext_a,
    input wire logic ext_b,
    // Count request
    output logic tick,
    output logic dir_down
);
    logic [3:0] prescale;
    logic a_q;
    logic b_q;
    logic a_edge;
    logic b_edge;

    // Prescaler gives a one-cycle enable for internal counting
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prescale <= tpf_pkg::ZERO4;
        end else if (prescale == tpf_pkg::PRESCALE_LAST) begin
            prescale <= tpf_pkg::ZERO4;
        end else begin
            prescale <= prescale + tpf_pkg::ONE4;
        end
    end

    // Previous pin levels; narrow pulses may be missed, the far end keeps widths
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            a_q <= 1'b0;
            b_q <= 1'b0;
        end else begin
            a_q <= ext_a;
            b_q <= ext_b;
        end
    end

    assign a_edge = ext_a ^ a_q;
    assign b_edge = ext_b ^ b_q;

    // Tick and direction per source; phase mode follows the 2-phase encoder
    always_comb begin
        tick = 1'b0;
        dir_down = down_sel;
        case (src)
            tpf_pkg::SRC_INTERNAL: tick = (prescale == tpf_pkg::PRESCALE_LAST);
            tpf_pkg::SRC_EXT_RISE: tick = ext_a & !a_q;
            tpf_pkg::SRC_EXT_BOTH: tick = a_edge;
            tpf_pkg::SRC_PHASE: begin
                tick = a_edge | b_edge;
                if (a_edge) begin
                    dir_down = !(ext_a ^ ext_b);
                end else begin
                    dir_down = ext_a ^ ext_b;
                end
            end
            default: tick = 1'b0;
        endcase
        if (halt) begin
            tick = 1'b0;
        end
    end
endmodule

// File: tpf_device.sv
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/1ns
module tpf_device (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic NRST,
    // Link to the bus side
    tpf_if.dev LINK,
    // External count clocks
    input wire logic EXT_CLK_A,
    input wire logic EXT_CLK_B,
    // Capture input and module stop
    input wire logic CAPTURE_IN,
    input wire logic MODULE_STOP,
    // Compare match output
    output logic MATCH_OUT
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [15:0] channel_up_down_counter;
    logic [15:0] general_match_capture_reg;
    logic [15:0] buffer_reg;
    logic [2:0] channel_status_reg;
    logic [2:0] read_as_one;
    logic [2:0] interrupt_enable_reg;
    logic [6:0] mode;
    logic capture_q;
    logic [2:0] next_status;
    logic [15:0] read_value;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic tick;
    logic dir_down;
    logic wr_commit;
    logic wr_counter;
    logic wr_match;
    logic wr_buffer;
    logic wr_status;
    logic rd_status;
    logic capture_mode;
    logic buffer_on;
    logic capture_ev;
    logic match_raw;
    logic match_hit;
    logic clear_ev;
    logic ovf_raw;
    logic udf_raw;
    logic [2:0] set_ev;

    tpf_count_source u_src (
        .clk(REF_CLK),
        .nrst(NRST),
        .src(mode[tpf_pkg::MODE_SRC_HI:tpf_pkg::MODE_SRC_LO]),
        .down_sel(mode[tpf_pkg::MODE_DOWN]),
        .halt(MODULE_STOP),
        .ext_a(EXT_CLK_A),
        .ext_b(EXT_CLK_B),
        .tick(tick),
        .dir_down(dir_down)
    );

    // Writes land in T2, reads are sampled in T1
    assign wr_commit = LINK.t2 & LINK.wr;
    assign wr_counter = wr_commit & (LINK.addr == tpf_pkg::REG_COUNTER);
    assign wr_match = wr_commit & (LINK.addr == tpf_pkg::REG_MATCH);
    assign wr_buffer = wr_commit & (LINK.addr == tpf_pkg::REG_BUFFER);
    assign wr_status = wr_commit & (LINK.addr == tpf_pkg::REG_STATUS);
    assign rd_status = LINK.t1 & !LINK.wr & (LINK.addr == tpf_pkg::REG_STATUS);
    assign capture_mode = mode[tpf_pkg::MODE_CAPTURE];
    assign buffer_on = mode[tpf_pkg::MODE_BUFFER];

    // Capture on a rising input edge, halted while stopped
    assign capture_ev = capture_mode & CAPTURE_IN & !capture_q & !MODULE_STOP;

    // Match only when the counter is about to move, so only once per tick
    assign match_raw = !capture_mode & tick &
                       (channel_up_down_counter == general_match_capture_reg);
    assign match_hit = match_raw & !wr_match;
    assign clear_ev = mode[tpf_pkg::MODE_CLEAR] & (match_hit | capture_ev);
    assign ovf_raw = tick & !dir_down & (channel_up_down_counter == tpf_pkg::MAX16);
    assign udf_raw = tick & dir_down & (channel_up_down_counter == tpf_pkg::ZERO16);

    // Flag sets; clear and counter write both cancel wrap flags
    always_comb begin
        set_ev = tpf_pkg::ZERO3;
        set_ev[tpf_pkg::FLAG_MATCH] = match_hit | capture_ev;
        set_ev[tpf_pkg::FLAG_OVF] = ovf_raw & !clear_ev & !wr_counter;
        set_ev[tpf_pkg::FLAG_UDF] = udf_raw & !clear_ev & !wr_counter;
    end

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    // Clear first, then the bus write, then the count step
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            channel_up_down_counter <= tpf_pkg::ZERO16;
        end else if (clear_ev) begin
            channel_up_down_counter <= tpf_pkg::ZERO16;
        end else if (wr_counter) begin
            channel_up_down_counter <= LINK.wdata;
        end else if (tick && dir_down) begin
            channel_up_down_counter <= channel_up_down_counter - tpf_pkg::ONE16;
        end else if (tick) begin
            channel_up_down_counter <= channel_up_down_counter + tpf_pkg::ONE16;
        end
    end

    // ------------------------------------------------------------
    // Match/capture and buffer registers
    // ------------------------------------------------------------
    // Capture wins over a bus write; buffer moves in on a match
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            general_match_capture_reg <= tpf_pkg::MAX16;
        end else if (capture_ev) begin
            general_match_capture_reg <= channel_up_down_counter;
        end else if (wr_match) begin
            general_match_capture_reg <= LINK.wdata;
        end else if (match_hit && buffer_on) begin
            general_match_capture_reg <= buffer_reg;
        end
    end

    // Buffer keeps the old match value on capture, dropping a bus write
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            buffer_reg <= tpf_pkg::MAX16;
        end else if (capture_ev && buffer_on) begin
            buffer_reg <= general_match_capture_reg;
        end else if (wr_buffer) begin
            buffer_reg <= LINK.wdata;
        end
    end

    // Capture edge detector
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            capture_q <= 1'b0;
        end else begin
            capture_q <= CAPTURE_IN;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            interrupt_enable_reg <= tpf_pkg::ZERO3;
            mode <= tpf_pkg::MODE_RESET;
        end else if (wr_commit && LINK.addr == tpf_pkg::REG_IRQ_ENABLE) begin
            interrupt_enable_reg <= LINK.wdata[2:0];
        end else if (wr_commit && LINK.addr == tpf_pkg::REG_MODE) begin
            mode <= LINK.wdata[6:0];
        end
    end

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    // Clears ignored while stopped; a set in the same cycle always wins
    always_comb begin
        next_status = channel_status_reg;
        if (wr_status && !MODULE_STOP) begin
            next_status = next_status & ~(read_as_one & ~LINK.wdata[2:0]);
        end
        if (LINK.xfer_ack && !MODULE_STOP) begin
            next_status[tpf_pkg::FLAG_MATCH] = 1'b0;
        end
        next_status = next_status | set_ev;
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            channel_status_reg <= tpf_pkg::ZERO3;
        end else begin
            channel_status_reg <= next_status;
        end
    end

    // Remember which flags software has seen as 1
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            read_as_one <= tpf_pkg::ZERO3;
        end else if (wr_status) begin
            read_as_one <= tpf_pkg::ZERO3;
        end else if (rd_status) begin
            read_as_one <= read_as_one | channel_status_reg;
        end
    end

    // Requests follow flag and enable; they fall with the flag
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            LINK.match_capture_irq <= 1'b0;
            LINK.overflow_irq <= 1'b0;
            LINK.underflow_irq <= 1'b0;
        end else begin
            LINK.match_capture_irq <= next_status[tpf_pkg::FLAG_MATCH] &
                                      interrupt_enable_reg[tpf_pkg::FLAG_MATCH];
            LINK.overflow_irq <= next_status[tpf_pkg::FLAG_OVF] &
                                 interrupt_enable_reg[tpf_pkg::FLAG_OVF];
            LINK.underflow_irq <= next_status[tpf_pkg::FLAG_UDF] &
                                  interrupt_enable_reg[tpf_pkg::FLAG_UDF];
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Sampled in T1; a capture in that cycle shows its new value
    always_comb begin
        read_value = tpf_pkg::ZERO16;
        case (LINK.addr)
            tpf_pkg::REG_COUNTER: read_value = channel_up_down_counter;
            tpf_pkg::REG_MATCH: read_value = capture_ev ? channel_up_down_counter
                                                        : general_match_capture_reg;
            tpf_pkg::REG_BUFFER: read_value = (capture_ev && buffer_on) ?
                                              general_match_capture_reg : buffer_reg;
            tpf_pkg::REG_STATUS: read_value = {13'h0000, channel_status_reg};
            tpf_pkg::REG_IRQ_ENABLE: read_value = {13'h0000, interrupt_enable_reg};
            tpf_pkg::REG_MODE: read_value = {9'h000, mode};
            default: read_value = tpf_pkg::ZERO16;
        endcase
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            LINK.rdata <= tpf_pkg::ZERO16;
        end else if (LINK.t1 && !LINK.wr) begin
            LINK.rdata <= read_value;
        end
    end

    // ------------------------------------------------------------
    // Compare output
    // ------------------------------------------------------------
    // Toggles on match; software keeps it off when the pin carries a clock
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            MATCH_OUT <= 1'b0;
        end else if (match_hit && mode[tpf_pkg::MODE_OUT_EN]) begin
            MATCH_OUT <= !MATCH_OUT;
        end
    end
endmodule

// File: tpf_host.sv
`timescale 1ns/1ns
module tpf_host (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic NRST,
    // Command port
    input wire logic [2:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [15:0] RDATA,
    // Link to the device
    tpf_if.host LINK
);
    tpf_pkg::tpf_hstate_t state;
    logic [2:0] target;
    logic [15:0] data;
    logic is_write;
    logic [15:0] result;
    logic dtc_en;
    logic [15:0] dtc_count;
    logic start;

    assign start = WR & (ADDR == tpf_pkg::HREG_CMD) & (state == tpf_pkg::HST_IDLE);

    // ------------------------------------------------------------
    // Command registers
    // ------------------------------------------------------------
    // Target and data are held steady across both link states
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            target <= tpf_pkg::ZERO3;
            data <= tpf_pkg::ZERO16;
            is_write <= 1'b0;
            dtc_en <= 1'b0;
        end else if (WR && state == tpf_pkg::HST_IDLE) begin
            case (ADDR)
                tpf_pkg::HREG_ADDR: target <= WDATA[2:0];
                tpf_pkg::HREG_DATA: data <= WDATA;
                tpf_pkg::HREG_CMD: is_write <= WDATA[tpf_pkg::CMD_WRITE];
                tpf_pkg::HREG_DTC_EN: dtc_en <= WDATA[0];
                default: target <= target;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Link cycle
    // ------------------------------------------------------------
    // One T1 then one T2; a command written before idle is dropped
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            state <= tpf_pkg::HST_IDLE;
            LINK.t1 <= 1'b0;
            LINK.t2 <= 1'b0;
            LINK.wr <= 1'b0;
            LINK.addr <= tpf_pkg::ZERO3;
            LINK.wdata <= tpf_pkg::ZERO16;
        end else begin
            case (state)
                tpf_pkg::HST_IDLE: begin
                    if (start) begin
                        state <= tpf_pkg::HST_T1;
                        LINK.t1 <= 1'b1;
                        LINK.wr <= WDATA[tpf_pkg::CMD_WRITE];
                        LINK.addr <= target;
                        LINK.wdata <= data;
                    end
                end
                tpf_pkg::HST_T1: begin
                    state <= tpf_pkg::HST_T2;
                    LINK.t1 <= 1'b0;
                    LINK.t2 <= 1'b1;
                end
                tpf_pkg::HST_T2: begin
                    state <= tpf_pkg::HST_IDLE;
                    LINK.t2 <= 1'b0;
                    LINK.wr <= 1'b0;
                end
                default: state <= tpf_pkg::HST_IDLE;
            endcase
        end
    end

    // Read data stands in T2 only
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            result <= tpf_pkg::ZERO16;
        end else if (state == tpf_pkg::HST_T2 && !is_write) begin
            result <= LINK.rdata;
        end
    end

    // ------------------------------------------------------------
    // Transfer controller
    // ------------------------------------------------------------
    // Unless the device is stopped, one activation per request; the request is gone the cycle after
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            LINK.xfer_ack <= 1'b0;
            dtc_count <= tpf_pkg::ZERO16;
        end else if (dtc_en && LINK.match_capture_irq && !LINK.xfer_ack) begin
            LINK.xfer_ack <= 1'b1;
            dtc_count <= dtc_count + tpf_pkg::ONE16;
        end else begin
            LINK.xfer_ack <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Command port read
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            RDATA <= tpf_pkg::ZERO16;
        end else if (RD) begin
            case (ADDR)
                tpf_pkg::HREG_ADDR: RDATA <= {13'h0000, target};
                tpf_pkg::HREG_DATA: RDATA <= data;
                tpf_pkg::HREG_RESULT: RDATA <= result;
                tpf_pkg::HREG_STATUS: RDATA <= {12'h000, LINK.underflow_irq,
                                               LINK.overflow_irq, LINK.match_capture_irq,
                                               state != tpf_pkg::HST_IDLE};
                tpf_pkg::HREG_DTC_EN: RDATA <= {15'h0000, dtc_en};
                tpf_pkg::HREG_DTC_COUNT: RDATA <= dtc_count;
                default: RDATA <= tpf_pkg::ZERO16;
            endcase
        end else begin
            RDATA <= tpf_pkg::ZERO16;
        end
    end
endmodule

// File: tpf_if.sv
`timescale 1ns/1ns
interface tpf_if;
    // Two-state bus cycle
    logic t1;
    logic t2;
    logic wr;
    logic [2:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    // Transfer controller activation
    logic xfer_ack;
    // Interrupt requests
    logic match_capture_irq;
    logic overflow_irq;
    logic underflow_irq;

    modport dev (
        input t1, t2, wr, addr, wdata, xfer_ack,
        output rdata, match_capture_irq, overflow_irq, underflow_irq
    );
    modport host (
        output t1, t2, wr, addr, wdata, xfer_ack,
        input rdata, match_capture_irq, overflow_irq, underflow_irq
    );
endinterface

// File: tpf_pkg.sv
package tpf_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int DATA_W = 16;
    localparam int ADDR_W = 3;
    localparam int FLAG_W = 3;

    // ------------------------------------------------------------
    // Device register indices on the link
    // ------------------------------------------------------------
    localparam logic [2:0] REG_COUNTER = 3'h0;
    localparam logic [2:0] REG_MATCH = 3'h1;
    localparam logic [2:0] REG_BUFFER = 3'h2;
    localparam logic [2:0] REG_STATUS = 3'h3;
    localparam logic [2:0] REG_IRQ_ENABLE = 3'h4;
    localparam logic [2:0] REG_MODE = 3'h5;

    // ------------------------------------------------------------
    // Status / enable bit positions
    // ------------------------------------------------------------
    localparam int FLAG_MATCH = 0;
    localparam int FLAG_OVF = 1;
    localparam int FLAG_UDF = 2;

    // ------------------------------------------------------------
    // Mode register fields
    // ------------------------------------------------------------
    localparam int MODE_SRC_LO = 0;
    localparam int MODE_SRC_HI = 1;
    localparam int MODE_CLEAR = 2;
    localparam int MODE_BUFFER = 3;
    localparam int MODE_CAPTURE = 4;
    localparam int MODE_DOWN = 5;
    localparam int MODE_OUT_EN = 6;
    localparam int MODE_W = 7;

    // Count source selections
    localparam logic [1:0] SRC_INTERNAL = 2'h0;
    localparam logic [1:0] SRC_EXT_RISE = 2'h1;
    localparam logic [1:0] SRC_EXT_BOTH = 2'h2;
    localparam logic [1:0] SRC_PHASE = 2'h3;

    // ------------------------------------------------------------
    // Reset values and fixed counts
    // ------------------------------------------------------------
    localparam logic [15:0] ZERO16 = 16'h0000;
    localparam logic [15:0] ONE16 = 16'h0001;
    localparam logic [15:0] MAX16 = 16'hFFFF;
    localparam logic [2:0] ZERO3 = 3'h0;
    localparam logic [6:0] MODE_RESET = 7'h00;
    localparam logic [3:0] PRESCALE_LAST = 4'h3;
    localparam logic [3:0] ZERO4 = 4'h0;
    localparam logic [3:0] ONE4 = 4'h1;

    // ------------------------------------------------------------
    // Host command port register indices
    // ------------------------------------------------------------
    localparam logic [2:0] HREG_ADDR = 3'h0;
    localparam logic [2:0] HREG_DATA = 3'h1;
    localparam logic [2:0] HREG_CMD = 3'h2;
    localparam logic [2:0] HREG_RESULT = 3'h3;
    localparam logic [2:0] HREG_STATUS = 3'h4;
    localparam logic [2:0] HREG_DTC_EN = 3'h5;
    localparam logic [2:0] HREG_DTC_COUNT = 3'h6;
    localparam int CMD_WRITE = 0;
    localparam int STAT_BUSY = 0;

    // Link cycle states of the host
    typedef enum logic [2:0] {
        HST_IDLE = 3'b001,
        HST_T1 = 3'b010,
        HST_T2 = 3'b100
    } tpf_hstate_t;
endpackage

// File: tpf_sva.sv
`timescale 1ns/1ns
module tpf_sva (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic NRST,
    // Link signals
    input wire logic t1,
    input wire logic t2,
    input wire logic wr,
    input wire logic [2:0] addr,
    input wire logic [15:0] rdata,
    input wire logic xfer_ack,
    input wire logic match_capture_irq,
    input wire logic overflow_irq,
    input wire logic underflow_irq
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!NRST);
    // ----------
    // Bus cycle steps
    // ----------
    sequence s_cycle;
        t1 ##1 t2;
    endsequence
    sequence s_cnt_wr;
        t2 && wr && addr == tpf_pkg::REG_COUNTER;
    endsequence
    // Enable writes lag one cycle, so a fall may come one or two cycles late
    wire clr_wr = t2 && wr && (addr == tpf_pkg::REG_STATUS || addr == tpf_pkg::REG_IRQ_ENABLE);
    a_t2_after_t1: assert property (t1 |-> s_cycle)
        else $error("t2 missing after t1");
    a_t2_has_t1: assert property (t2 |-> $past(t1))
        else $error("t2 without t1");
    a_req_held: assert property (s_cycle |-> $stable(wr) && $stable(addr))
        else $error("request moved within cycle");
    a_rdata_on_read: assert property ($changed(rdata) |-> $past(t1 && !wr))
        else $error("read data moved without read");
    a_cnt_wr_noflag: assert property (s_cnt_wr |=>
        !$rose(overflow_irq) && !$rose(underflow_irq))
        else $error("wrap flag during counter write");
    a_ack_on_irq: assert property (xfer_ack |-> match_capture_irq)
        else $error("transfer without request");
    a_ack_clears: assert property (xfer_ack |=> !match_capture_irq)
        else $error("transfer did not clear request");
    a_wrap_fall_cause: assert property (($fell(overflow_irq) || $fell(underflow_irq)) |->
        $past(clr_wr) || $past(clr_wr, 2))
        else $error("wrap request fell unprompted");
    a_match_fall_cause: assert property ($fell(match_capture_irq) |->
        $past(clr_wr) || $past(clr_wr, 2) || $past(xfer_ack))
        else $error("match request fell unprompted");
endmodule
